// File: shared/ssr_defines.svh
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH
// ----------------------------------------------------------------
// Status byte bit positions
// ----------------------------------------------------------------
`define SSR_STB_RQS        6
`define SSR_STB_ESB        5
`define SSR_STB_MAV        4
`define SSR_STB_USED_MASK  8'h70
`define SSR_STB_RSV_MASK   8'h8f
// ----------------------------------------------------------------
// Standard event bit positions
// ----------------------------------------------------------------
`define SSR_EV_PON         7
`define SSR_EV_CME         5
`define SSR_EV_EXE         4
`define SSR_EV_QYE         2
`define SSR_EV_OPC         0
`define SSR_EV_USED_MASK   8'hb5
`define SSR_EV_RSV_MASK    8'h4a
`define SSR_ZERO8          8'h00
`define SSR_QDEPTH         16
`define SSR_QAW            4
`endif

// File: shared/ssr_pkg.sv
package ssr_pkg;
	// Event inputs raised by the command layer, one-cycle pulses.
	typedef struct packed {
		logic opc_done;
		logic cmd_err;
		logic exe_err;
		logic query_err;
	} ssr_events_t;
	// Register commands from the command layer, one-cycle pulses.
	typedef struct packed {
		logic       sre_wr;
		logic       ese_wr;
		logic [7:0] wdata;
		logic       esr_rd;
		logic       cls;
		logic       dev_clr;
		logic       new_msg;
		logic       serial_poll;
	} ssr_cmd_t;
	typedef enum logic [1:0] {
		SSR_LINK_GPIB  = 2'b00,
		SSR_LINK_RS232 = 2'b01
	} ssr_link_t;
endpackage : ssr_pkg

// File: core/ssr_event_reg.sv
`timescale 1ns/10ps
`include "ssr_defines.svh"
// Sticky standard event register with enable mask and summary.
module ssr_event_reg
	import ssr_pkg::*;
(
	input  wire logic             sys_clk,   // System clock.
	input  wire logic             rst,       // Synchronous reset.
	input  wire logic             pon_clr,   // Clear enable at power-up.
	input  ssr_pkg::ssr_events_t  ev,        // Event pulses.
	input  wire logic             set_qye,   // Query error from queue.
	input  wire logic             clr,       // Read or clear status.
	input  wire logic             ese_wr,    // Enable write strobe.
	input  wire logic [7:0]       wdata,     // Enable write data.
	output logic [7:0]            standard_event_status,       // Event register value.
	output logic [7:0]            ese,       // Enable register value.
	output logic                  esb        // Masked summary.
);
	typedef struct packed {
		logic [7:0] standard_event_status;
		logic [7:0] ese;
		logic       first;
	} ssr_evst_t;
	ssr_evst_t st_reg;
	ssr_evst_t st_next;
	logic [7:0] set_v;
	// Gather set requests; a set in the clearing cycle wins.
	always_comb
	begin
		set_v = `SSR_ZERO8;
		set_v[`SSR_EV_CME] = ev.cmd_err;
		set_v[`SSR_EV_EXE] = ev.exe_err;
		set_v[`SSR_EV_QYE] = ev.query_err | set_qye;
		set_v[`SSR_EV_OPC] = ev.opc_done;
		set_v[`SSR_EV_PON] = st_reg.first;
		st_next = st_reg;
		st_next.first = 1'b0;
		if (clr)
			st_next.standard_event_status = set_v & `SSR_EV_USED_MASK;
		else
			st_next.standard_event_status = (st_reg.standard_event_status | set_v) & `SSR_EV_USED_MASK;
		if (ese_wr)
			st_next.ese = wdata;
	end
	// Register the state; enable survives reset unless power-on clear.
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			st_reg.standard_event_status   <= `SSR_ZERO8;
			st_reg.first <= 1'b1;
			if (pon_clr)
				st_reg.ese <= `SSR_ZERO8;
		end
		else
			st_reg <= st_next;
	end
	assign standard_event_status = st_reg.standard_event_status;
	assign ese = st_reg.ese;
	assign esb = |(st_reg.standard_event_status & st_reg.ese);
endmodule : ssr_event_reg

// File: core/ssr_out_queue.sv
`timescale 1ns/10ps
`include "ssr_defines.svh"
// Output response queue whose occupancy feeds message-available.
module ssr_out_queue
	import ssr_pkg::*;
#(
	parameter int DEPTH = `SSR_QDEPTH,
	parameter int AW    = `SSR_QAW
)
(
	input  wire logic       sys_clk,   // System clock.
	input  wire logic       rst,       // Synchronous reset.
	input  wire logic       flush,     // Discard contents.
	input  wire logic       wr,        // Push a byte.
	input  wire logic [7:0] wdata,     // Byte pushed.
	input  wire logic       rd,        // Pop a byte.
	output logic [7:0]      rdata,     // Head byte.
	output logic            not_empty, // At least one byte held.
	output logic            full       // No room.
);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} ssr_qst_t;
	ssr_qst_t   st_reg;
	ssr_qst_t   st_next;
	logic [7:0] mem [DEPTH];
	logic       do_wr;
	logic       do_rd;
	assign do_wr = wr && !full && !flush;
	assign do_rd = rd && not_empty && !flush;
	// Pointer and count update; flush wins over traffic.
	always_comb
	begin
		st_next = st_reg;
		if (flush)
			st_next = '0;
		else
		begin
			if (do_wr)
				st_next.wp = st_reg.wp + 1'b1;
			if (do_rd)
				st_next.rp = st_reg.rp + 1'b1;
			if (do_wr && !do_rd)
				st_next.cnt = st_reg.cnt + 1'b1;
			else if (do_rd && !do_wr)
				st_next.cnt = st_reg.cnt - 1'b1;
		end
	end
	// State register.
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	// Storage array.
	always_ff @(posedge sys_clk)
	begin
		if (do_wr)
			mem[st_reg.wp] <= wdata;
	end
	assign rdata     = mem[st_reg.rp];
	assign not_empty = (st_reg.cnt != '0);
	assign full      = (st_reg.cnt == (AW+1)'(DEPTH));
endmodule : ssr_out_queue

// File: core/ssr_status_report.sv
`timescale 1ns/10ps
`include "ssr_defines.svh"
// ----------------------------------------------------------------
// Status reporting top
// ----------------------------------------------------------------
// What this block does
// - Raise service request by driving the open-collector request line low on the bus link.
// - Status byte bits 7, 3, 2, 1, 0 always read zero.
// - Request flag sets when masked summary rises from zero to one.
// - Request flag clears on summary fall, power-up, or serial poll.
// - Status query bit 6 carries current masked summary level.
// - Bit 5 is OR of event bits masked by event enable.
// - Bit 4 is one whenever the output queue holds a byte.
// - Request enable register is writable, readable and gates the request.
// - Event enable writable, readable; power-up clear follows setting only.
// - Event register clears when read or on clear-status.
// - Power-on event bit sets after each power-up.
// - Command error event bit sets on syntax error.
// - Execution error event bit sets on failed command.
// - Event bits 6, 3, 1 always stay zero.
// - Query error bit sets on unrequested read or interrupted response.
// - Operation complete bit sets when pending operations finish.
// - Output queue empties at power-up and on device clear.
// - New message with unread output on the bus link flags query error, flushes queue.
// - Serial link accepts new message during output without query error.
module ssr_status_report
	import ssr_pkg::*;
(
	input  wire logic            sys_clk,     // System clock, 20 MHz.
	input  wire logic            rst,         // Synchronous reset, power-up.
	input  wire logic            pon_clr,     // Power-on clear setting.
	input  ssr_pkg::ssr_link_t   link,        // Active remote link.
	input  ssr_pkg::ssr_cmd_t    cmd,         // Register commands.
	input  ssr_pkg::ssr_events_t ev,          // Event pulses.
	input  wire logic            q_wr,        // Response byte push.
	input  wire logic [7:0]      q_wdata,     // Response byte.
	input  wire logic            q_rd,        // Response byte pop.
	output logic [7:0]           q_rdata,     // Head response byte.
	output logic                 q_full,      // Queue full.
	output logic [7:0]           stb_query,   // Status byte for query.
	output logic [7:0]           poll_byte,   // Serial poll response.
	output logic [7:0]           esr_value,   // Event register value.
	output logic [7:0]           ese_value,   // Event enable value.
	output logic [7:0]           sre_value,   // Request enable value.
	output logic                 srq_drv,     // Request line drive value.
	output logic                 srq_oe       // Request line enable.
);
	typedef struct packed {
		logic [7:0] sre;
		logic       rqs;
		logic       mss_d;
		logic [7:0] stb_q;
		logic [7:0] poll;
		logic [7:0] esr_o;
		logic [7:0] ese_o;
		logic [7:0] qd;
		logic       qf;
		logic       srq_oe;
		logic       srq_drv;
	} ssr_top_t;
	ssr_top_t   st_reg;
	ssr_top_t   st_next;
	logic [7:0] esr_w;
	logic [7:0] ese_w;
	logic       esb_w;
	logic       mav_w;
	logic       qfull_w;
	logic [7:0] qrd_w;
	logic       qerr;
	logic       qflush;
	logic [7:0] sb;
	logic       mss;
	// ----------------------------------------------------------------
	// Summary helpers
	// ----------------------------------------------------------------
	// True when any bit of a register survives its enable mask.
	function automatic logic ssr_any_masked(input logic [7:0] val, input logic [7:0] mask);
		return |(val & mask);
	endfunction : ssr_any_masked
	// ----------------------------------------------------------------
	// Query error and flush
	// ----------------------------------------------------------------
	// Unread output on a new message is an error only on the bus link.
	assign qerr   = cmd.new_msg && mav_w && (link == SSR_LINK_GPIB);
	assign qflush = cmd.dev_clr || qerr;
	// ----------------------------------------------------------------
	// Sub-blocks
	// ----------------------------------------------------------------
	// Standard event register with its enable mask.
	ssr_event_reg u_ev
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.pon_clr (pon_clr),
		.ev      (ev),
		.set_qye (qerr),
		.clr     (cmd.esr_rd || cmd.cls),
		.ese_wr  (cmd.ese_wr),
		.wdata   (cmd.wdata),
		.standard_event_status     (esr_w),
		.ese     (ese_w),
		.esb     (esb_w)
	);
	// Response queue; its occupancy is message-available.
	ssr_out_queue u_q
	(
		.sys_clk   (sys_clk),
		.rst       (rst),
		.flush     (qflush),
		.wr        (q_wr),
		.wdata     (q_wdata),
		.rd        (q_rd),
		.rdata     (qrd_w),
		.not_empty (mav_w),
		.full      (qfull_w)
	);
	// ----------------------------------------------------------------
	// Status byte and request flag
	// ----------------------------------------------------------------
	// Live status byte with unused positions forced low.
	always_comb
	begin
		sb = `SSR_ZERO8;
		sb[`SSR_STB_ESB] = esb_w;
		sb[`SSR_STB_MAV] = mav_w;
		sb = sb & `SSR_STB_USED_MASK;
		mss = ssr_any_masked(sb, st_reg.sre);
	end
	// Next state: request flag edges, enable write, registered outputs.
	always_comb
	begin
		st_next = st_reg;
		st_next.mss_d = mss;
		if (cmd.sre_wr)
			st_next.sre = cmd.wdata;
		if (mss && !st_reg.mss_d)
			st_next.rqs = 1'b1;
		else if ((!mss && st_reg.mss_d) || cmd.serial_poll)
			st_next.rqs = 1'b0;
		st_next.stb_q = sb;
		st_next.stb_q[`SSR_STB_RQS] = mss;
		st_next.poll = sb;
		st_next.poll[`SSR_STB_RQS] = st_next.rqs;
		st_next.esr_o = esr_w;
		st_next.ese_o = ese_w;
		st_next.qd = qrd_w;
		st_next.qf = qfull_w;
		st_next.srq_oe = st_next.rqs && (link == SSR_LINK_GPIB);
		st_next.srq_drv = 1'b0;
	end
	// State register; request enable clears at power-up only if selected.
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			st_reg.rqs    <= 1'b0;
			st_reg.mss_d  <= 1'b0;
			st_reg.stb_q  <= `SSR_ZERO8;
			st_reg.poll   <= `SSR_ZERO8;
			st_reg.esr_o  <= `SSR_ZERO8;
			st_reg.ese_o  <= `SSR_ZERO8;
			st_reg.qd     <= `SSR_ZERO8;
			st_reg.qf     <= 1'b0;
			st_reg.srq_oe <= 1'b0;
			st_reg.srq_drv <= 1'b0;
			if (pon_clr)
				st_reg.sre <= `SSR_ZERO8;
		end
		else
			st_reg <= st_next;
	end
	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every output comes straight from a register.
	assign stb_query = st_reg.stb_q;
	assign poll_byte = st_reg.poll;
	assign esr_value = st_reg.esr_o;
	assign ese_value = st_reg.ese_o;
	assign sre_value = st_reg.sre;
	assign q_rdata   = st_reg.qd;
	assign q_full    = st_reg.qf;
	assign srq_drv   = st_reg.srq_drv;
	assign srq_oe    = st_reg.srq_oe;
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_unused_zero;
		@(posedge sys_clk) disable iff (rst)
		(stb_query & `SSR_STB_RSV_MASK) == `SSR_ZERO8 &&
		(poll_byte & `SSR_STB_RSV_MASK) == `SSR_ZERO8;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused status bit set");
	property p_rqs_rise;
		@(posedge sys_clk) disable iff (rst)
		(mss && !st_reg.mss_d && !cmd.serial_poll) |=> poll_byte[`SSR_STB_RQS];
	endproperty
	a_rqs_rise: assert property (p_rqs_rise) else $error("request flag missed rise");
	property p_rqs_poll;
		@(posedge sys_clk) disable iff (rst)
		(cmd.serial_poll && !(mss && !st_reg.mss_d)) |=> !poll_byte[`SSR_STB_RQS];
	endproperty
	a_rqs_poll: assert property (p_rqs_poll) else $error("poll did not clear flag");
	property p_mss;
		@(posedge sys_clk) disable iff (rst)
		1'b1 |=> stb_query[`SSR_STB_RQS] == $past(mss);
	endproperty
	a_mss: assert property (p_mss) else $error("summary bit wrong");
	property p_esb;
		@(posedge sys_clk) disable iff (rst)
		stb_query[`SSR_STB_ESB] == ssr_any_masked(esr_value, ese_value);
	endproperty
	a_esb: assert property (p_esb) else $error("event summary wrong");
	property p_esr_clear;
		@(posedge sys_clk) disable iff (rst)
		(cmd.cls && ev == '0 && !qerr && !$past(rst)) |=> ##1 esr_value == `SSR_ZERO8;
	endproperty
	a_esr_clear: assert property (p_esr_clear) else $error("event register not cleared");
	property p_unused_ev;
		@(posedge sys_clk) disable iff (rst)
		(esr_value & `SSR_EV_RSV_MASK) == `SSR_ZERO8;
	endproperty
	a_unused_ev: assert property (p_unused_ev) else $error("unused event bit set");
	property p_qye;
		@(posedge sys_clk) disable iff (rst)
		qerr |=> !mav_w ##1 esr_value[`SSR_EV_QYE];
	endproperty
	a_qye: assert property (p_qye) else $error("query error not flagged");
	property p_sticky;
		@(posedge sys_clk) disable iff (rst)
		(esr_w[`SSR_EV_EXE] && !cmd.esr_rd && !cmd.cls) |=> esr_w[`SSR_EV_EXE];
	endproperty
	a_sticky: assert property (p_sticky) else $error("event bit lost");
	property p_srq;
		@(posedge sys_clk) disable iff (rst)
		srq_oe |-> (poll_byte[`SSR_STB_RQS] && link == SSR_LINK_GPIB) || $changed(link);
	endproperty
	a_srq: assert property (p_srq) else $error("request driven without flag");
	// Message-available and event summary reach both answers alike.
	property p_mav;
		@(posedge sys_clk) disable iff (rst)
		1'b1 |=> stb_query[`SSR_STB_MAV] == $past(mav_w);
	endproperty
	a_mav: assert property (p_mav) else $error("message available wrong");
	property p_poll_same;
		@(posedge sys_clk) disable iff (rst)
		poll_byte[`SSR_STB_ESB:`SSR_STB_MAV] == stb_query[`SSR_STB_ESB:`SSR_STB_MAV];
	endproperty
	a_poll_same: assert property (p_poll_same) else $error("poll and query differ");
	// The request flag drops with the summary and pulls the line while set on the bus link.
	property p_rqs_fall;
		@(posedge sys_clk) disable iff (rst)
		(!mss && st_reg.mss_d) |=> !poll_byte[`SSR_STB_RQS];
	endproperty
	a_rqs_fall: assert property (p_rqs_fall) else $error("request flag kept");
	property p_srq_drive;
		@(posedge sys_clk) disable iff (rst)
		(st_next.rqs && link == SSR_LINK_GPIB) |=> srq_oe && !srq_drv;
	endproperty
	a_srq_drive: assert property (p_srq_drive) else $error("request line not pulled");
	// Enable writes land, and clear-status leaves the request enable alone.
	property p_sre_write;
		@(posedge sys_clk) disable iff (rst)
		cmd.sre_wr |=> sre_value == $past(cmd.wdata);
	endproperty
	a_sre_write: assert property (p_sre_write) else $error("request enable wrong");
	property p_ese_write;
		@(posedge sys_clk) disable iff (rst)
		cmd.ese_wr |=> ##1 ese_value == $past(cmd.wdata, 2);
	endproperty
	a_ese_write: assert property (p_ese_write) else $error("event enable wrong");
	property p_sre_keep;
		@(posedge sys_clk) disable iff (rst)
		(cmd.cls && !cmd.sre_wr) |=> $stable(sre_value);
	endproperty
	a_sre_keep: assert property (p_sre_keep) else $error("request enable lost");
	// Power-on flag, read clear, queue discard and serial queue keep.
	property p_pon;
		@(posedge sys_clk) disable iff (rst)
		$past(rst) |=> ##1 esr_value[`SSR_EV_PON];
	endproperty
	a_pon: assert property (p_pon) else $error("power-on flag missing");
	property p_esr_read;
		@(posedge sys_clk) disable iff (rst)
		(cmd.esr_rd && ev == '0 && !qerr && !$past(rst)) |=> ##1 esr_value == `SSR_ZERO8;
	endproperty
	a_esr_read: assert property (p_esr_read) else $error("event register not read clear");
	property p_flush;
		@(posedge sys_clk) disable iff (rst)
		cmd.dev_clr |=> !mav_w;
	endproperty
	a_flush: assert property (p_flush) else $error("queue not emptied");
	property p_serial_keep;
		@(posedge sys_clk) disable iff (rst)
		(cmd.new_msg && link == SSR_LINK_RS232 && mav_w && !cmd.dev_clr && !q_rd)
		|=> mav_w;
	endproperty
	a_serial_keep: assert property (p_serial_keep) else $error("serial output lost");
	// ----------------------------------------------------------------
	// Coverage
	// ----------------------------------------------------------------
	// Main scenarios that the tests must reach.
	c_srq: cover property (@(posedge sys_clk) disable iff (rst) $rose(srq_oe));
	c_qerr: cover property (@(posedge sys_clk) disable iff (rst) qerr);
	c_poll: cover property (@(posedge sys_clk) disable iff (rst) cmd.serial_poll && poll_byte[6]);
	c_set_wins: cover property (@(posedge sys_clk) disable iff (rst) cmd.esr_rd && ev.exe_err);
	c_serial_msg: cover property (@(posedge sys_clk) disable iff (rst)
		cmd.new_msg && mav_w && link == SSR_LINK_RS232);
endmodule : ssr_status_report

// File: test/ssr_ctrl_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Remote bus controller model
// ----------------------------------------------------------------
// Resolves the wired-OR request line and counts the requests seen.
module ssr_ctrl_model
(
	sys_clk,      // System clock.
	srq_drv,      // Device drive value on the request line.
	srq_oe,       // Device enable on the request line.
	srq_line_n,   // Resolved request line, low when requested.
	srq_count     // Number of request assertions seen.
);
	input  wire logic        sys_clk;
	input  wire logic        srq_drv;
	input  wire logic        srq_oe;
	output logic             srq_line_n;
	output logic [7:0]       srq_count;

	logic line_prev;

	// The line has a pull-up, so it is high unless a party drives it.
	assign srq_line_n = srq_oe ? srq_drv : 1'b1;

	// A falling line is one request; the cause is found by poll or query.
	initial
	begin
		srq_count = 8'h00;
		line_prev = 1'b1;
	end
	always @(posedge sys_clk)
	begin
		if (line_prev && !srq_line_n)
			srq_count <= srq_count + 8'h01;
		line_prev <= srq_line_n;
	end
endmodule : ssr_ctrl_model

// File: test/status_report_service_request_bench.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Status reporting testbench
// ----------------------------------------------------------------
module status_report_service_request_bench;
	import ssr_pkg::*;

	logic          sys_clk, rst, pon_clr, q_wr, q_rd, srq_drv, srq_oe, srq_line_n, q_full;
	ssr_link_t     link;
	ssr_cmd_t      cmd;
	ssr_events_t   ev;
	logic [7:0]    q_wdata, q_rdata, stb_query, poll_byte, esr_value, ese_value, sre_value;
	logic [7:0]    srq_count;
	int            num_errors, tests_run;
	ssr_events_t   ev_tab [4];
	logic [7:0]    ev_mask [4];

	ssr_status_report uut (.sys_clk(sys_clk), .rst(rst), .pon_clr(pon_clr), .link(link),
		.cmd(cmd), .ev(ev), .q_wr(q_wr), .q_wdata(q_wdata), .q_rd(q_rd),
		.q_rdata(q_rdata), .q_full(q_full), .stb_query(stb_query), .poll_byte(poll_byte),
		.esr_value(esr_value), .ese_value(ese_value), .sre_value(sre_value),
		.srq_drv(srq_drv), .srq_oe(srq_oe));

	ssr_ctrl_model ctrl (.sys_clk(sys_clk), .srq_drv(srq_drv), .srq_oe(srq_oe),
		.srq_line_n(srq_line_n), .srq_count(srq_count));

	// ----------------------------------------------------------------
	// Clock and watchdog
	// ----------------------------------------------------------------
	// The clock runs at 20 MHz.
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// The whole sequence needs well under 1000 cycles.
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		num_errors = num_errors + 1;
		end_sim();
	end

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	// Compares one value and counts the result.
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp)
		begin
			num_errors = num_errors + 1;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Waits n edges and lets their updates land.
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : settle

	// Issues one register command for a single cycle.
	task automatic send(input ssr_cmd_t c);
		@(posedge sys_clk);
		cmd <= c;
		@(posedge sys_clk);
		cmd <= '0;
		settle(4);
	endtask : send

	// Issues one set of event pulses for a single cycle.
	task automatic raise(input ssr_events_t e);
		@(posedge sys_clk);
		ev <= e;
		@(posedge sys_clk);
		ev <= '0;
		settle(4);
	endtask : raise

	// Pushes n response bytes back to back.
	task automatic q_push(input int n, input logic [7:0] first);
		for (int i = 0; i < n; i++)
		begin
			@(posedge sys_clk);
			q_wr    <= 1'b1;
			q_wdata <= first + 8'(i);
		end
		@(posedge sys_clk);
		q_wr <= 1'b0;
		settle(4);
	endtask : q_push

	// Holds power-up reset for ten cycles.
	task automatic power_up(input logic clr_en);
		@(posedge sys_clk);
		rst     <= 1'b1;
		pon_clr <= clr_en;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		settle(4);
	endtask : power_up

	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial
	begin
		num_errors = 0;
		tests_run  = 0;
		rst = 1'b1; pon_clr = 1'b1; link = SSR_LINK_GPIB; cmd = '0; ev = '0;
		q_wr = 1'b0; q_wdata = 8'h00; q_rd = 1'b0;
		ev_tab  = '{'{opc_done:1'b1, default:1'b0}, '{cmd_err:1'b1, default:1'b0},
			'{exe_err:1'b1, default:1'b0}, '{query_err:1'b1, default:1'b0}};
		ev_mask = '{8'h01, 8'h20, 8'h10, 8'h04};
		power_up(1'b1);
		check("esr after power-up", esr_value, 8'h80);
		check("sre after power-up", sre_value, 8'h00);
		check("ese after power-up", ese_value, 8'h00);
		check("stb after power-up", stb_query, 8'h00);
		send('{esr_rd:1'b1, default:'0});
		check("esr after read", esr_value, 8'h00);
		// Each event code sets its own bit, which stays until read.
		for (int i = 0; i < 4; i++)
		begin
			raise(ev_tab[i]);
			settle(20);
			check("esr event bit", esr_value, ev_mask[i]);
			send('{esr_rd:1'b1, default:'0});
		end
		raise('1);
		check("esr all events", esr_value, 8'h35);
		// An event that meets a read in the same cycle survives the read.
		@(posedge sys_clk);
		ev  <= '{exe_err:1'b1, default:1'b0};
		cmd <= '{esr_rd:1'b1, default:'0};
		@(posedge sys_clk);
		ev  <= '0;
		cmd <= '0;
		settle(4);
		check("esr set wins", esr_value, 8'h10);
		send('{esr_rd:1'b1, default:'0});
		// Event summary through the enable mask, request still masked off.
		send('{ese_wr:1'b1, wdata:8'h10, default:'0});
		check("ese readback", ese_value, 8'h10);
		raise('{exe_err:1'b1, default:1'b0});
		check("stb event summary", stb_query, 8'h20);
		check("poll event summary", poll_byte, 8'h20);
		check("line with sre clear", srq_line_n, 8'h01);
		send('{sre_wr:1'b1, wdata:8'h20, default:'0});
		check("sre readback", sre_value, 8'h20);
		check("stb master summary", stb_query, 8'h60);
		check("poll request flag", poll_byte, 8'h60);
		check("request line low", srq_line_n, 8'h00);
		check("request count", srq_count, 8'h01);
		// A serial poll clears the request flag but not the summary.
		send('{serial_poll:1'b1, default:'0});
		check("poll after poll", poll_byte, 8'h20);
		check("stb after poll", stb_query, 8'h60);
		check("line after poll", srq_line_n, 8'h01);
		send('{cls:1'b1, default:'0});
		check("esr after clear", esr_value, 8'h00);
		check("stb after clear", stb_query, 8'h00);
		check("sre after clear", sre_value, 8'h20);
		raise('{exe_err:1'b1, default:1'b0});
		check("poll on new rise", poll_byte, 8'h60);
		send('{esr_rd:1'b1, default:'0});
		check("poll on fall", poll_byte, 8'h00);
		check("line on fall", srq_line_n, 8'h01);
		// Message available follows the output queue.
		q_push(1, 8'h5a);
		check("stb with byte", stb_query, 8'h10);
		check("head byte", q_rdata, 8'h5a);
		@(posedge sys_clk);
		q_rd <= 1'b1;
		@(posedge sys_clk);
		q_rd <= 1'b0;
		settle(4);
		check("stb after pop", stb_query, 8'h00);
		q_push(16, 8'h00);
		check("queue full", q_full, 8'h01);
		send('{dev_clr:1'b1, default:'0});
		check("stb after dev clear", stb_query, 8'h00);
		check("full after dev clear", q_full, 8'h00);
		// New message over unread output on the bus link.
		q_push(2, 8'h11);
		send('{new_msg:1'b1, default:'0});
		check("esr query error", esr_value, 8'h04);
		check("stb after flush", stb_query, 8'h00);
		send('{esr_rd:1'b1, default:'0});
		// Full-duplex serial link keeps the queue and raises no request.
		@(posedge sys_clk);
		link <= SSR_LINK_RS232;
		send('{sre_wr:1'b1, wdata:8'h10, default:'0});
		q_push(1, 8'h33);
		check("stb serial", stb_query, 8'h50);
		check("line serial", srq_line_n, 8'h01);
		send('{new_msg:1'b1, default:'0});
		check("stb serial new msg", stb_query, 8'h50);
		check("esr serial new msg", esr_value, 8'h00);
		// Second power-up that keeps the enable registers.
		power_up(1'b0);
		check("esr second power-up", esr_value, 8'h80);
		check("stb second power-up", stb_query, 8'h00);
		check("sre kept", sre_value, 8'h10);
		check("ese kept", ese_value, 8'h10);
		check("request count end", srq_count, 8'h02);
		end_sim();
	end
endmodule : status_report_service_request_bench
